// *** core/tie_top.sv ***
// top-level interrupt enable set/clear block with apb register access
`timescale 1ns/10ps
`include "tie_params.svh"
module tie_top #(
    parameter int NUM_SRC = `TIE_NUM_SRC
) (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire tie_pkg::tie_apb_req_t  apb_req,
    output tie_pkg::tie_apb_rsp_t       apb_rsp,
    input  wire logic [NUM_SRC-1:0]     src_raw,
    input  wire tie_pkg::tie_sub_flags_t sub_flags,
    input  wire tie_pkg::tie_sub_flags_t sub_enables,
    output logic [NUM_SRC-1:0]          nvic_request,
    output logic [NUM_SRC-1:0]          enable_vector,
    output logic                        block_irq
);
    import tie_pkg::*;

    logic [NUM_SRC-1:0]          enable;
    logic [NUM_SRC-1:0]          next_enable;
    logic [NUM_SRC-1:0]          src_meta;
    logic [NUM_SRC-1:0]          src_sync;
    logic [`TIE_EVT_W-1:0]       evt_status;
    logic [`TIE_EVT_W-1:0]       evt_mask;
    logic [31:0]                 rdata;
    logic [NUM_SRC-1:0]          request_q;
    logic [31:0]                 prdata_q;
    wire                         rsp_ready;

    wire                         conv_level;
    wire                         ser1_level;
    wire                         ser2_level;
    wire                         tim2_level;
    wire                         tim1_level;
    wire [NUM_SRC-1:0]           src_level;
    wire [NUM_SRC-1:0]           deliver;

    // ---- bus decode ----
    wire access     = apb_req.psel & apb_req.penable;
    wire wr_access  = access & apb_req.pwrite;
    wire rd_access  = access & ~apb_req.pwrite;
    wire hit_set    = apb_req.paddr == `TIE_OFS_ENABLE_SET; // RULE1
    wire hit_clr    = apb_req.paddr == `TIE_OFS_ENABLE_CLR; // RULE4
    wire hit_status = apb_req.paddr == `TIE_OFS_STATUS;
    wire hit_mask   = apb_req.paddr == `TIE_OFS_MASK;
    wire hit_any    = hit_set | hit_clr | hit_status | hit_mask;
    wire bad_addr   = access & ~hit_any;

    // upper pwdata bits are dropped so unassigned bits never store
    wire [NUM_SRC-1:0] wr_bits = apb_req.pwdata[NUM_SRC-1:0]; // RULE12
    wire [NUM_SRC-1:0] set_bits = (wr_access & hit_set) ? wr_bits : '0; // RULE2
    wire [NUM_SRC-1:0] clr_bits = (wr_access & hit_clr) ? wr_bits : '0; // RULE5 RULE9

    wire [`TIE_EVT_W-1:0] evt_clr =
        (wr_access & hit_status) ? apb_req.pwdata[`TIE_EVT_W-1:0] : '0;
    wire [`TIE_EVT_W-1:0] evt_raise;

    // zeros leave bits alone; the two registers never share an address
    assign next_enable = (enable | set_bits) & ~clr_bits; // RULE3

    // ---- second-level merges ----
    tie_level_merge #(.WIDTH(5)) u_conv (
        .flags   (sub_flags.converter),
        .enables (sub_enables.converter),
        .level   (conv_level)
    );
    tie_level_merge #(.WIDTH(15)) u_ser1 (
        .flags   (sub_flags.serial_one),
        .enables (sub_enables.serial_one),
        .level   (ser1_level)
    );
    tie_level_merge #(.WIDTH(13)) u_ser2 (
        .flags   (sub_flags.serial_two),
        .enables (sub_enables.serial_two),
        .level   (ser2_level)
    );
    tie_level_merge #(.WIDTH(7)) u_tim2 (
        .flags   (sub_flags.timer_two),
        .enables (sub_enables.timer_two),
        .level   (tim2_level)
    );
    tie_level_merge #(.WIDTH(7)) u_tim1 (
        .flags   (sub_flags.timer_one),
        .enables (sub_enables.timer_one),
        .level   (tim1_level)
    );

    // direct sources come through the synchroniser; grouped ones also OR in their merge
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            if (g == `TIE_BIT_CONVERTER) begin : g_conv
                assign src_level[g] = conv_level | src_sync[g]; // RULE7 RULE10
            end else if (g == `TIE_BIT_SERIAL_TWO) begin : g_s2
                assign src_level[g] = ser2_level | src_sync[g]; // RULE8 RULE10
            end else if (g == `TIE_BIT_SERIAL_ONE) begin : g_s1
                assign src_level[g] = ser1_level | src_sync[g]; // RULE8 RULE10
            end else if (g == `TIE_BIT_TIMER_TWO) begin : g_t2
                assign src_level[g] = tim2_level | src_sync[g]; // RULE8 RULE10
            end else if (g == `TIE_BIT_TIMER_ONE) begin : g_t1
                assign src_level[g] = tim1_level | src_sync[g]; // RULE8 RULE10
            end else begin : g_direct
                assign src_level[g] = src_sync[g]; // RULE6
            end
            assign deliver[g] = src_level[g] & enable[g]; // RULE13
        end
    endgenerate

    // ---- block events ----
    assign evt_raise[`TIE_EVT_ENABLED]  = |(set_bits & ~enable);
    assign evt_raise[`TIE_EVT_DISABLED] = |(clr_bits & enable);
    assign evt_raise[`TIE_EVT_BAD_ADDR] = bad_addr;
    assign evt_raise[`TIE_EVT_DELIVER]  = |(deliver & ~request_q);

    // ---- read mux ----
    always_comb begin
        rdata = `TIE_WORD_ZERO;
        if (hit_set | hit_clr) begin
            rdata[NUM_SRC-1:0] = enable; // RULE12
        end else if (hit_status) begin
            rdata[`TIE_EVT_W-1:0] = evt_status;
        end else if (hit_mask) begin
            rdata[`TIE_EVT_W-1:0] = evt_mask;
        end
    end

    // ---- registers ----
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            src_meta <= '0;
            src_sync <= '0;
        end else begin
            src_meta <= src_raw;
            src_sync <= src_meta;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            enable <= `TIE_ENABLE_RST; // RULE1 RULE4
        end else begin
            enable <= next_enable;
        end
    end

    // a new event beats a write-one clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            evt_status <= '0;
            evt_mask   <= '0;
        end else begin
            evt_status <= (evt_status & ~evt_clr) | evt_raise;
            if (wr_access & hit_mask) begin
                evt_mask <= apb_req.pwdata[`TIE_EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            request_q      <= '0;
            block_irq      <= 1'b0;
            prdata_q       <= `TIE_WORD_ZERO;
        end else begin
            request_q <= deliver;
            block_irq <= |((evt_status & ~evt_clr | evt_raise) & evt_mask);
            if (rd_access) begin
                prdata_q <= rdata;
            end
        end
    end

    // one wait state on reads; prdata is registered so the read answer comes one edge late
    // pready therefore waits one cycle on reads and is immediate on writes
    logic rd_done;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_done <= 1'b0;
        end else begin
            rd_done <= rd_access & ~rd_done;
        end
    end

    // the response struct has one driver, assembled here from its parts
    assign rsp_ready       = wr_access | rd_done;
    assign apb_rsp         = '{pready: rsp_ready, pslverr: bad_addr & rsp_ready, prdata: prdata_q};
    assign nvic_request    = request_q;
    assign enable_vector   = enable;
endmodule // tie_top

// *** core/tie_params.svh ***
// constants, offsets and rule overview for the top-level interrupt enable block
// Overview of operation
// RULE1 - The enable-set register sits at offset 0x0100 and resets to all zeros.
// RULE2 - Writing a 1 to an enable-set bit enables that top-level source.
// RULE3 - Writing a 0 to any bit of either register leaves that enable unchanged.
// RULE4 - The enable-clear register sits at offset 0x0180 and resets to all zeros.
// RULE5 - Writing a 1 to an enable-clear bit disables that top-level source.
// RULE6 - Bit 16 is debug and bits 15 down to 12 are external lines d, c, b and a.
// RULE7 - Bit 11 is the converter, 10 mac receive, 9 mac transmit, 8 mac timer, 7 security.
// RULE8 - Bits 6 and 5 are serial controllers two and one, then sleep timer, baseband, management, timers.
// RULE9 - The enable-clear register uses the same bit layout as the enable-set register.
// RULE10 - Second-level flags feed a top-level source as a level, held while any enabled flag is set.
// RULE11 - A top-level source fed by second-level flags stays up until all those flags are cleared.
// RULE12 - Reading either register returns the 17-bit enable vector, upper bits zero and read-only.
// RULE13 - A source request reaches the vectored controller only while its enable bit is set.
`ifndef TIE_PARAMS_SVH
`define TIE_PARAMS_SVH

`define TIE_NUM_SRC        17
`define TIE_OFS_ENABLE_SET 12'h100
`define TIE_OFS_ENABLE_CLR 12'h180
`define TIE_OFS_STATUS     12'h040
`define TIE_OFS_MASK       12'h044
`define TIE_ADDR_W         12
`define TIE_ENABLE_RST     17'h00000
`define TIE_WORD_ZERO      32'h00000000

`define TIE_BIT_TIMER_ONE  0
`define TIE_BIT_TIMER_TWO  1
`define TIE_BIT_SERIAL_ONE 5
`define TIE_BIT_SERIAL_TWO 6
`define TIE_BIT_CONVERTER  11

`define TIE_EVT_W          4
`define TIE_EVT_ENABLED    0
`define TIE_EVT_DISABLED   1
`define TIE_EVT_BAD_ADDR   2
`define TIE_EVT_DELIVER    3

`endif

// *** core/tie_pkg.sv ***
// types shared by the top-level interrupt enable block
package tie_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tie_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tie_apb_rsp_t;

    // second-level flag groups for sources that have them
    typedef struct packed {
        logic [4:0]  converter;
        logic [14:0] serial_one;
        logic [12:0] serial_two;
        logic [6:0]  timer_two;
        logic [6:0]  timer_one;
    } tie_sub_flags_t;
endpackage

// *** core/tie_level_merge.sv ***
// merges a group of second-level flags and their enables into one level source
`timescale 1ns/10ps
module tie_level_merge #(
    parameter int WIDTH = 7
) (
    input  wire logic [WIDTH-1:0] flags,
    input  wire logic [WIDTH-1:0] enables,
    output logic                  level
);
    import tie_pkg::*;

    wire [WIDTH-1:0] live;

    // no latching here: the source falls only when every enabled flag is gone
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            assign live[g] = flags[g] & enables[g]; // RULE10
        end
    endgenerate

    assign level = |live; // RULE11
endmodule // tie_level_merge

// *** verif/tie_nvic_model.sv ***
// processor-side model that latches every delivered request
`timescale 1ns/10ps
module tie_nvic_model #(
    parameter int NUM_SRC = 17
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic [NUM_SRC-1:0] nvic_request,
    output logic      [NUM_SRC-1:0] pending
);
    always_ff @(posedge core_clk) begin
        if (sys_rst) pending <= '0;
        else pending <= pending | nvic_request;
    end
endmodule // tie_nvic_model

// *** verif/tie_props.sv ***
// port assertions for the interrupt enable block
`timescale 1ns/10ps
module tie_props #(
    parameter int NUM_SRC = 17
) (
    input wire logic                   core_clk,
    input wire logic                   sys_rst,
    input wire tie_pkg::tie_apb_req_t  apb_req,
    input wire tie_pkg::tie_apb_rsp_t  apb_rsp,
    input wire logic [NUM_SRC-1:0]     nvic_request,
    input wire logic [NUM_SRC-1:0]     enable_vector
);
    import tie_pkg::*;
    wire               acc = apb_req.psel & apb_req.penable & apb_rsp.pready;
    wire [11:0]        a = apb_req.paddr;
    wire               wr_set = acc & apb_req.pwrite & (a == 12'h100);
    wire               wr_clr = acc & apb_req.pwrite & (a == 12'h180);
    wire               en_reg = (a == 12'h100) | (a == 12'h180);
    wire               mapped = en_reg | (a == 12'h040) | (a == 12'h044);
    wire [NUM_SRC-1:0] wd = apb_req.pwdata[NUM_SRC-1:0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence rd_start;
        $rose(apb_req.psel && apb_req.penable) && !apb_req.pwrite;
    endsequence
    sequence rd_wait;
        !apb_rsp.pready ##1 apb_rsp.pready;
    endsequence
    set_bits_a: assert property (wr_set |=> enable_vector == ($past(enable_vector) | $past(wd)))
        else $error("set write result wrong");
    clear_bits_a: assert property (wr_clr |=> enable_vector == ($past(enable_vector) & ~$past(wd)))
        else $error("clear write result wrong");
    enable_hold_a: assert property (!(wr_set || wr_clr) |=> $stable(enable_vector))
        else $error("enable changed without write");
    gated_req_a: assert property ((nvic_request & ~$past(enable_vector)) == '0)
        else $error("request passed while disabled");
    read_data_a: assert property (acc && !apb_req.pwrite && en_reg |-> apb_rsp.prdata == 32'(enable_vector))
        else $error("read data not enable vector");
    bad_addr_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
        else $error("error response wrong");
    write_wait_a: assert property ($rose(apb_req.psel && apb_req.penable) && apb_req.pwrite |-> apb_rsp.pready)
        else $error("write not answered at once");
    read_wait_a: assert property (rd_start |-> rd_wait)
        else $error("read answer timing wrong");
endmodule // tie_props
bind tie_top tie_props #(.NUM_SRC(NUM_SRC)) i_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .nvic_request(nvic_request),
    .enable_vector(enable_vector));

// *** verif/tb_top_irq_enable_set_clear.sv ***
// self-checking bench for the interrupt enable block
`timescale 1ns/10ps
module tb_top_irq_enable_set_clear;
    import tie_pkg::*;
    logic clk, rst, irq, err;
    tie_apb_req_t req;
    tie_apb_rsp_t rsp;
    tie_sub_flags_t flg, fen;
    logic [16:0] src, nreq, env, pend;
    logic [31:0] rd;
    int bad_count = 0;
    int cmp_count = 0;
    tie_top i_dut (.core_clk(clk), .sys_rst(rst), .apb_req(req), .apb_rsp(rsp), .src_raw(src),
        .sub_flags(flg), .sub_enables(fen), .nvic_request(nreq), .enable_vector(env),
        .block_irq(irq));
    tie_nvic_model i_nvic (.core_clk(clk), .sys_rst(rst), .nvic_request(nreq), .pending(pend));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        req.psel <= 1'b1; req.pwrite <= w; req.paddr <= a; req.pwdata <= d;
        @(posedge clk) req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_regs;
        apb(1'b0, 12'h100, 0); chk("set reset", 0, rd);
        apb(1'b0, 12'h180, 0); chk("clear reset", 0, rd);
        apb(1'b1, 12'h100, 32'h00010000); chk("debug on", 32'h10000, env);
        apb(1'b1, 12'h100, 32'hfffe0020); chk("upper ignored", 32'h10020, env);
        apb(1'b1, 12'h180, 0); chk("zero write", 32'h10020, env);
        apb(1'b0, 12'h180, 0); chk("clear read", 32'h10020, rd);
        apb(1'b1, 12'h180, 32'h20); chk("serial one off", 32'h10000, env);
        apb(1'b1, 12'h180, 32'h10000); chk("debug off", 0, env);
    endtask
    task automatic t_deliver;
        src <= 17'h1ffff;
        apb(1'b1, 12'h100, 32'h0aaaa);
        repeat (4) @(posedge clk);
        chk("alternate map", 32'h0aaaa, nreq);
        apb(1'b1, 12'h100, 32'h1ffff);
        repeat (2) @(posedge clk);
        chk("all sources", 32'h1ffff, nreq);
        chk("model saw all", 32'h1ffff, pend);
        src <= '0;
        apb(1'b1, 12'h180, 32'h1ffff);
        repeat (3) @(posedge clk);
        chk("all off", 0, nreq);
    endtask
    task automatic t_level;
        fen.timer_one <= 7'h08; flg.timer_one <= 7'h08; flg.serial_two <= 13'h1;
        apb(1'b1, 12'h100, 32'h41);
        repeat (2) @(posedge clk);
        chk("flag level", 32'h1, nreq);
        flg.timer_one <= 7'h00;
        repeat (3) @(posedge clk);
        chk("flag cleared", 0, nreq);
    endtask
    task automatic t_irq;
        apb(1'b1, 12'h044, 32'h4);
        apb(1'b0, 12'h3fc, 0); chk("bad addr err", 1, err);
        chk("bad addr data", 0, rd); chk("irq up", 1, irq);
        apb(1'b1, 12'h044, 0);
        @(posedge clk);
        chk("irq masked", 0, irq);
        apb(1'b1, 12'h040, 32'h4); apb(1'b1, 12'h044, 32'h4); chk("irq cleared", 0, irq);
    endtask
    task automatic close_out;
        $display("comparisons %0d errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #100us;
        bad_count++;
        close_out;
    end
    initial begin
        rst = 1'b1; req = '0; src = '0; flg = '0; fen = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_deliver;
        t_level;
        t_irq;
        close_out;
    end
endmodule // tb_top_irq_enable_set_clear
